// [include/pag_map.vh]
// register map, field positions and timing constants for pulse acceptance gating
`ifndef PAG_MAP_VH
`define PAG_MAP_VH

// ****************
// register offsets
// ****************
`define PAG_CTRL_OFS     12'h000
`define PAG_STATUS_OFS   12'h004
`define PAG_ACC_CNT_OFS  12'h008
`define PAG_REJ_CNT_OFS  12'h00C
`define PAG_PEAK_CNT_OFS 12'h010

// ****************
// control fields
// ****************
`define PAG_CTRL_ANALYZE 0
`define PAG_CTRL_CLRCNT  1
`define PAG_CTRL_RESET   32'h00000000

// ****************
// status fields
// ****************
`define PAG_ST_OCCUPIED  0
`define PAG_ST_ENGAGED   1
`define PAG_ST_REJECT    2
`define PAG_ST_CLAMP     3
`define PAG_ST_DEAD      4
`define PAG_ST_LOWER     5
`define PAG_ST_UPPER     6
`define PAG_ST_FLOOR     7
`define PAG_ST_ZERO      8
`define PAG_ST_ANALYZE   9

// ****************
// timing
// ****************
`define PAG_CLK_NS       10
`define PAG_PULSE_NS     50
`define PAG_PULSE_CYC    ((`PAG_PULSE_NS + `PAG_CLK_NS - 1) / `PAG_CLK_NS)
`define PAG_CNT_W        16

`endif

// [hw/pag_sync.v]
// two-stage synchroniser for asynchronous comparator levels
`timescale 1ns/10ps
`default_nettype none

module pag_sync #(
	parameter WIDTH = 5
) (
	input  wire             pclk,    // clock
	input  wire             presetn, // async reset, active low
	input  wire [WIDTH-1:0] async_in, // levels from analog front end
	output wire [WIDTH-1:0] sync_out  // synchronised levels
);

	reg [WIDTH-1:0] meta;
	reg [WIDTH-1:0] stable;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta[i]   <= 1'b0;
					stable[i] <= 1'b0;
				end else begin
					meta[i]   <= async_in[i];
					stable[i] <= meta[i];
				end
			end
		end
	endgenerate

	assign sync_out = stable;

endmodule // pag_sync

`default_nettype wire

// [hw/pag_pulse.v]
// fixed-length one-shot, retriggers ignored while running
`timescale 1ns/10ps
`default_nettype none

module pag_pulse #(
	parameter CYC = 5,
	parameter CW  = 4
) (
	input  wire pclk,    // clock
	input  wire presetn, // async reset, active low
	input  wire fire,    // start request, one cycle
	output reg  active,  // high for CYC cycles
	output reg  done     // one-cycle pulse at trailing edge
);

	reg [CW-1:0] count;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count  <= {CW{1'b0}};
			active <= 1'b0;
			done   <= 1'b0;
		end else begin
			done <= 1'b0;
			if (active) begin
				if (count == CYC[CW-1:0] - 1'b1) begin
					active <= 1'b0;
					done   <= 1'b1;
					count  <= {CW{1'b0}};
				end else begin
					count <= count + 1'b1;
				end
			end else if (fire) begin
				active <= 1'b1;
				count  <= {CW{1'b0}};
			end
		end
	end

endmodule // pag_pulse

`default_nettype wire

// [hw/pag_gating.v]
// start-of-conversion acceptance and reject gating with APB registers
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "pag_map.vh"

module pag_gating #(
	parameter PULSE_CYC = `PAG_PULSE_CYC,
	parameter CNT_W     = `PAG_CNT_W
) (
	input  wire        pclk,               // 100 MHz clock
	input  wire        presetn,            // async reset, active low
	input  wire        psel,               // apb select
	input  wire        penable,            // apb access phase
	input  wire        pwrite,             // apb write
	input  wire [11:0] paddr,              // apb byte address
	input  wire [31:0] pwdata,             // apb write data
	output reg  [31:0] prdata,             // apb read data
	output wire        pready,             // apb ready
	output wire        pslverr,            // apb error, unmapped
	input  wire        peak_trigger,       // peak seen, async level
	input  wire        lower_window_pass,  // above lower window, async
	input  wire        upper_window_trip,  // above upper window, async
	input  wire        above_floor_level,  // above floor, async
	input  wire        zero_bias_pass,     // above zero bias, async
	input  wire        conv_clear,         // end of conversion, store/clear
	output reg         peak_strobe_n,      // 50 ns low strobe
	output reg         gated_strobe_n,     // 50 ns low, analyze gated
	output reg         stretcher_occupied_latch,   // conversion started
	output reg         stretcher_occupied_latch_n, // complement
	output reg         converter_engaged,  // converter busy
	output reg         reject_latch,       // reject state
	output reg         strong_discharge,   // low-ohm stretcher shunt
	output reg         slow_discharge_en,  // high-ohm stretcher shunt
	output reg         stretcher_clamp_hold, // clamp hold
	output reg         dead_time,          // live-time correction
	output reg         reject_reset,       // internal reset pulse
	output reg         store_inhibit       // store suppressed
);

	// ****************
	// input synchronisation
	// ****************
	wire [4:0] s_in;
	wire       s_trig;
	wire       s_lower;
	wire       s_upper;
	wire       s_floor;
	wire       s_zero;

	pag_sync #(
		.WIDTH(5)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.async_in({zero_bias_pass, above_floor_level,
			upper_window_trip, lower_window_pass, peak_trigger}),
		.sync_out(s_in)
	);

	assign s_trig  = s_in[0];
	assign s_lower = s_in[1];
	assign s_upper = s_in[2];
	assign s_floor = s_in[3];
	assign s_zero  = s_in[4];

	// ****************
	// register state
	// ****************
	reg                analyze_en;
	reg                trig_q;
	reg                clamp_q;
	reg  [3*CNT_W-1:0] evt_cnt;
	wire [CNT_W-1:0]   acc_cnt;
	wire [CNT_W-1:0]   rej_cnt;
	wire [CNT_W-1:0]   peak_cnt;

	// ****************
	// peak strobe
	// ****************
	wire trig_rise;
	wire peak_fire;
	wire gate_fire;
	wire peak_active;
	wire gate_active;
	wire gate_done;

	assign trig_rise = s_trig & ~trig_q;
	assign peak_fire = trig_rise & s_lower & ~reject_latch;
	assign gate_fire = peak_fire & analyze_en;

	pag_pulse #(
		.CYC(PULSE_CYC),
		.CW (4)
	) u_peak (
		.pclk   (pclk),
		.presetn(presetn),
		.fire   (peak_fire),
		.active (peak_active),
		.done   ()
	);

	pag_pulse #(
		.CYC(PULSE_CYC),
		.CW (4)
	) u_gate (
		.pclk   (pclk),
		.presetn(presetn),
		.fire   (gate_fire),
		.active (gate_active),
		.done   (gate_done)
	);

	// ****************
	// next-state logic
	// ****************
	reg next_occupied;
	reg next_engaged;
	reg next_reject;
	reg next_clamp;
	reg occ_set;
	reg rej_set;
	reg rej_sensed;

	always @* begin
		// no reject may stand when the gated strobe ends
		occ_set    = gate_done & ~reject_latch & s_zero;
		// engaged with reject and floor gone: handed over as a reject
		rej_sensed = converter_engaged & reject_latch & ~s_floor;
		rej_set    = s_upper & ~reject_latch;

		next_occupied = stretcher_occupied_latch;
		if (!s_zero)
			next_occupied = 1'b0;
		else if (occ_set)
			next_occupied = 1'b1;

		next_engaged = converter_engaged;
		if (occ_set)
			next_engaged = 1'b1;
		else if (rej_sensed || conv_clear)
			next_engaged = 1'b0;

		next_clamp = s_floor | next_engaged;

		// an upper trip still high wins over the clamp-fall clear
		next_reject = reject_latch;
		if (s_upper)
			next_reject = 1'b1;
		else if (clamp_q && !next_clamp)
			next_reject = 1'b0;
	end

	// ****************
	// peak and gated strobes
	// ****************
	// straight from the one-shot flops: low for exactly PULSE_CYC cycles
	always @* begin
		peak_strobe_n  = ~peak_active;
		gated_strobe_n = ~gate_active;
	end

	// ****************
	// edge history
	// ****************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_q  <= 1'b0;
			clamp_q <= 1'b0;
		end else begin
			trig_q  <= s_trig;
			clamp_q <= next_clamp;
		end
	end

	// ****************
	// stretcher occupied latch
	// ****************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stretcher_occupied_latch   <= 1'b0;
			stretcher_occupied_latch_n <= 1'b1;
		end else begin
			stretcher_occupied_latch   <= next_occupied;
			stretcher_occupied_latch_n <= ~next_occupied;
		end
	end

	// ****************
	// engaged and reject latches
	// ****************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			converter_engaged <= 1'b0;
			reject_latch      <= 1'b0;
			strong_discharge  <= 1'b0;
		end else begin
			converter_engaged <= next_engaged;
			reject_latch      <= next_reject;
			strong_discharge  <= next_reject;
		end
	end

	// ****************
	// clamp hold, discharge and dead time
	// ****************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stretcher_clamp_hold <= 1'b0;
			slow_discharge_en    <= 1'b1;
			dead_time            <= 1'b0;
		end else begin
			stretcher_clamp_hold <= next_clamp;
			slow_discharge_en    <= ~next_clamp;
			dead_time            <= next_clamp | s_lower;
		end
	end

	// ****************
	// reject reset and store inhibit
	// ****************
	// a reject sensed with a new start in one cycle keeps the store blocked
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reject_reset  <= 1'b0;
			store_inhibit <= 1'b0;
		end else begin
			reject_reset <= rej_sensed;
			if (rej_sensed)
				store_inhibit <= 1'b1;
			else if (occ_set)
				store_inhibit <= 1'b0;
		end
	end

	// ****************
	// apb slave
	// ****************
	wire       wr_en;
	wire       rd_setup;
	reg        mapped;
	reg [31:0] rd_word;
	wire [31:0] status_word;

	assign pready   = 1'b1;
	assign wr_en    = psel & penable & pwrite & mapped;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pslverr  = psel & penable & ~mapped;

	assign status_word = {22'h000000, analyze_en, s_zero, s_floor,
		s_upper, s_lower, dead_time, stretcher_clamp_hold,
		reject_latch, converter_engaged, stretcher_occupied_latch};

	always @* begin
		mapped  = 1'b1;
		rd_word = 32'h00000000;
		case (paddr)
			`PAG_CTRL_OFS:
				rd_word = {31'h00000000, analyze_en};
			`PAG_STATUS_OFS:
				rd_word = status_word;
			`PAG_ACC_CNT_OFS:
				rd_word[CNT_W-1:0] = acc_cnt;
			`PAG_REJ_CNT_OFS:
				rd_word[CNT_W-1:0] = rej_cnt;
			`PAG_PEAK_CNT_OFS:
				rd_word[CNT_W-1:0] = peak_cnt;
			default:
				mapped = 1'b0;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (rd_setup) begin
			prdata <= rd_word;
		end
	end

	// ****************
	// control and event counters
	// ****************
	localparam [31:0] CTRL_RST = `PAG_CTRL_RESET;

	wire       ctrl_wr;
	wire       clr_cnt;
	wire [2:0] cnt_evt;

	assign ctrl_wr = wr_en & (paddr == `PAG_CTRL_OFS);
	assign clr_cnt = ctrl_wr & pwdata[`PAG_CTRL_CLRCNT];
	assign cnt_evt = {peak_fire, rej_set, occ_set};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			analyze_en <= CTRL_RST[`PAG_CTRL_ANALYZE];
		end else if (ctrl_wr) begin
			analyze_en <= pwdata[`PAG_CTRL_ANALYZE];
		end
	end

	// one counter per event: accepted, rejected, peak strobes
	// an event and a clear in the same cycle leave the counter at 1
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_cnt
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					evt_cnt[gi*CNT_W +: CNT_W] <= {CNT_W{1'b0}};
				end else if (cnt_evt[gi]) begin
					evt_cnt[gi*CNT_W +: CNT_W] <= clr_cnt
						? {{(CNT_W-1){1'b0}}, 1'b1}
						: evt_cnt[gi*CNT_W +: CNT_W] + 1'b1;
				end else if (clr_cnt) begin
					evt_cnt[gi*CNT_W +: CNT_W] <= {CNT_W{1'b0}};
				end
			end
		end
	endgenerate

	assign acc_cnt  = evt_cnt[CNT_W-1:0];
	assign rej_cnt  = evt_cnt[2*CNT_W-1:CNT_W];
	assign peak_cnt = evt_cnt[3*CNT_W-1:2*CNT_W];

endmodule // pag_gating

`default_nettype wire

// [test/pag_front.sv]
// analog front end model: comparator levels for one pulse
`timescale 1ns/10ps
`default_nettype none
module pag_front (
	input  wire logic       pclk,              // clock
	input  wire logic       go,                // start one pulse
	input  wire logic [1:0] amp,               // 0 low, 1 window, 2 over, 3 late over
	output logic            peak_trigger,      // peak seen
	output logic            lower_window_pass, // lower window
	output logic            upper_window_trip, // upper window
	output logic            above_floor_level, // floor
	output logic            zero_bias_pass     // zero bias
);
	logic [5:0] step;
	logic       on;
	initial step = 6'h00;
	always @(posedge pclk) begin
		if (go)
			step <= 6'h01;
		else if (step != 6'h00)
			step <= (step == 6'h28) ? 6'h00 : step + 6'h01;
	end
	// pulse lasts 30 steps, peak early in it at steps 6 to 9
	assign on = (step != 6'h00) && (step <= 6'h1E);
	assign above_floor_level = on;
	assign zero_bias_pass = on;
	assign lower_window_pass = on && (amp != 2'h0);
	assign upper_window_trip = on && amp[1] && (!amp[0] || (step >= 6'h09));
	assign peak_trigger = (step >= 6'h06) && (step <= 6'h09);
endmodule // pag_front
`default_nettype wire

// [test/pag_gating_asserts.sv]
// concurrent checks on the gating block ports
`timescale 1ns/10ps
`default_nettype none
module pag_gating_asserts (
	input wire logic pclk,                       // clock
	input wire logic presetn,                    // reset, active low
	input wire logic peak_strobe_n,              // strobe
	input wire logic gated_strobe_n,             // gated strobe
	input wire logic stretcher_occupied_latch,   // occupied
	input wire logic stretcher_occupied_latch_n, // complement
	input wire logic converter_engaged,          // engaged
	input wire logic reject_latch,               // reject
	input wire logic strong_discharge,           // strong shunt
	input wire logic slow_discharge_en,          // slow shunt
	input wire logic stretcher_clamp_hold,       // clamp
	input wire logic dead_time,                  // dead time
	input wire logic reject_reset,               // reset pulse
	input wire logic store_inhibit               // store blocked
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_low5;
		!peak_strobe_n [*5] ##1 peak_strobe_n;
	endsequence
	sequence s_gate_end;
		$past(gated_strobe_n) && !$past(gated_strobe_n, 2);
	endsequence
	a_strobe_len: assert property ($fell(peak_strobe_n) |-> s_low5)
		else $error("strobe length wrong");
	a_gate_needs: assert property (!gated_strobe_n |-> !peak_strobe_n)
		else $error("gated strobe without strobe");
	a_occ_trail: assert property ($rose(stretcher_occupied_latch) |-> s_gate_end)
		else $error("occupied set off trailing edge");
	a_occ_comp: assert property (stretcher_occupied_latch != stretcher_occupied_latch_n)
		else $error("occupied complement wrong");
	a_occ_reject: assert property ($rose(stretcher_occupied_latch) |-> !$past(reject_latch))
		else $error("occupied set under reject");
	a_fire_norej: assert property ($fell(peak_strobe_n) |-> !$past(reject_latch))
		else $error("strobe fired under reject");
	a_clamp_rej: assert property ($fell(stretcher_clamp_hold) |-> !reject_latch)
		else $error("reject held after clamp fell");
	a_strong_rej: assert property (strong_discharge == reject_latch)
		else $error("strong discharge mismatch");
	a_eng_clamp: assert property (converter_engaged |-> stretcher_clamp_hold)
		else $error("clamp low while engaged");
	a_occ_engage: assert property ($rose(stretcher_occupied_latch) |-> converter_engaged)
		else $error("engaged not set");
	a_rej_sensed: assert property (reject_reset |-> ##[0:1] (!converter_engaged && store_inhibit))
		else $error("reject reset incomplete");
	a_slow_inv: assert property (slow_discharge_en != stretcher_clamp_hold)
		else $error("slow discharge mismatch");
	a_dead_clamp: assert property (stretcher_clamp_hold |-> dead_time)
		else $error("dead time low under clamp");
endmodule // pag_gating_asserts
`default_nettype wire
bind pag_gating pag_gating_asserts u_pag_gating_asserts (.pclk, .presetn, .peak_strobe_n,
	.gated_strobe_n, .stretcher_occupied_latch, .stretcher_occupied_latch_n, .converter_engaged,
	.reject_latch, .strong_discharge, .slow_discharge_en, .stretcher_clamp_hold, .dead_time,
	.reject_reset, .store_inhibit);

// [test/tb_pulse_accept_reject_gating.sv]
// testbench for the pulse acceptance gating block
`timescale 1ns/10ps
`default_nettype none
module tb_pulse_accept_reject_gating;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, conv_clear = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [1:0] amp = 2'h0;
	logic pready, pslverr, err, pt, lw, uw, fl, zb, ps, gs, oc, ocn, en, rj, sd, sl, cl, dt, rr, si;
	int bad_count = 0, n_compared = 0;
	pag_front u_pag_front (.pclk(pclk), .go(go), .amp(amp), .peak_trigger(pt),
		.lower_window_pass(lw), .upper_window_trip(uw), .above_floor_level(fl),
		.zero_bias_pass(zb));
	pag_gating u_pag_gating (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .peak_trigger(pt), .lower_window_pass(lw), .upper_window_trip(uw),
		.above_floor_level(fl), .zero_bias_pass(zb), .conv_clear(conv_clear),
		.peak_strobe_n(ps), .gated_strobe_n(gs), .stretcher_occupied_latch(oc),
		.stretcher_occupied_latch_n(ocn), .converter_engaged(en), .reject_latch(rj),
		.strong_discharge(sd), .slow_discharge_en(sl), .stretcher_clamp_hold(cl),
		.dead_time(dt), .reject_reset(rr), .store_inhibit(si));
	always #5 pclk = ~pclk;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	// one front end pulse, stopping at step 26 while its levels are still high
	task hit(input logic [1:0] a);
		@(posedge pclk);
		{go, amp} <= {1'b1, a};
		@(posedge pclk);
		go <= 1'b0;
		repeat (25) @(posedge pclk);
	endtask
	task tail;
		repeat (20) @(posedge pclk);
	endtask
	task t_reset;
		rd(12'h000, 32'h0);
		rd(12'h004, 32'h0);
		rd(12'h014, 32'h0);
		chk(err, 1'b1);
	endtask
	task t_accept;
		apb(1'b1, 12'h000, 32'h1);
		hit(2'h1);
		chk({oc, ocn, en, cl, sl, dt}, 6'h2D);
		tail;
		chk({oc, en, cl}, 3'h3);
	endtask
	task t_eng_rej;
		hit(2'h2);
		chk({rj, sd, oc}, 3'h6);
		tail;
		chk({en, si, rj, sl}, 4'h5);
	endtask
	task t_off;
		apb(1'b1, 12'h000, 32'h0);
		hit(2'h1);
		chk(oc, 1'b0);
		tail;
	endtask
	task t_low;
		apb(1'b1, 12'h000, 32'h1);
		hit(2'h0);
		chk({oc, dt}, 2'h1);
		tail;
	endtask
	task t_reject;
		hit(2'h2);
		chk({rj, sd, oc, dt}, 4'hD);
		tail;
		chk({rj, sd, cl, sl, dt}, 5'h02);
	endtask
	// upper trip rises after the strobe fired but before it ends
	task t_late;
		hit(2'h3);
		chk({rj, oc, en}, 3'h4);
		tail;
	endtask
	task t_clear;
		hit(2'h1);
		tail;
		@(posedge pclk);
		conv_clear <= 1'b1;
		@(posedge pclk);
		conv_clear <= 1'b0;
		repeat (3) @(posedge pclk);
		chk({en, cl, sl, si}, 4'h2);
		rd(12'h008, 32'h2);
		rd(12'h00C, 32'h3);
		rd(12'h010, 32'h4);
	endtask
	task end_of_test;
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge pclk);
		bad_count++;
		end_of_test;
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_accept;
		t_eng_rej;
		t_off;
		t_low;
		t_reject;
		t_late;
		t_clear;
		end_of_test;
	end
endmodule // tb_pulse_accept_reject_gating
`default_nettype wire
